// >>> src/iod_io_space.sv
// iod_io_space: I/O register space of the core, with bit ops and data-space window
//
// Contract
// - bit set/clear only on locations 0x00-0x1F
// - skip ops test one bit, low 32
// - some status flags clear on writing one
// - bit ops touch only the addressed bit
// - transfer ops use I/O addresses 0x00-0x3F
// - data address equals I/O address plus 0x20
// - transfer opcode encodes exactly 64 locations
// - extended area reached only by memory ops
`timescale 1ns/1ps

module iod_io_space (
	input  wire logic               mclk,      // system clock, 20 MHz
	input  wire logic               rst,       // synchronous reset, high
	input  wire iod_pkg::iod_req_s  req,       // request from execution unit
	output iod_pkg::iod_rsp_s       rsp,       // answer to execution unit
	input  wire iod_pkg::iod_pins_s pins,      // asynchronous pad levels
	input  wire iod_pkg::iod_evt_s  evt,       // flag set pulses
	output iod_pkg::iod_ports_s     ports,     // port direction and output
	output iod_pkg::iod_ext_s       ext,       // extended area access
	input  wire logic [7:0]         ext_rdata  // extended read data, strobe cycle
);

	////////////////////////////////////////////////////////////////////////
	// state

	// whole state of the block
	typedef struct packed {
		logic [iod_pkg::IO_LOCATIONS-1:0][7:0] mem;  // 64 locations
		iod_pkg::iod_pins_s sync1;  // first synchroniser stage
		iod_pkg::iod_pins_s sync2;  // second synchroniser stage
		iod_pkg::iod_rsp_s  rsp;    // registered answer
		iod_pkg::iod_ext_s  ext;    // registered extended access
		logic               ext_pend;  // extended read awaiting data
	} iod_state_s;

	iod_state_s q;  // registered state
	iod_state_s n;  // next state

	////////////////////////////////////////////////////////////////////////
	// helpers

	// hardware level for one location, from the synchronised pads
	function automatic logic [7:0] lvl_value(
		input logic [5:0]         a,
		input iod_pkg::iod_pins_s p
	);
		unique case (a)
			iod_pkg::PORT_B_PIN_INPUT:          return p.b;
			iod_pkg::PORT_C_PIN_INPUT:          return p.c;
			iod_pkg::PORT_D_PIN_INPUT:          return p.d;
			iod_pkg::PORT_E_PIN_INPUT:          return p.e;
			iod_pkg::COMPARATOR_CONTROL_STATUS: return {2'h0, p.ac_out, 5'h00};
			default:                            return 8'h00;
		endcase
	endfunction

	// flag set pulses aimed at one location
	function automatic logic [7:0] evt_value(
		input logic [5:0]        a,
		input iod_pkg::iod_evt_s e
	);
		unique case (a)
			iod_pkg::TIMER0_FLAGS:              return e.timer0;
			iod_pkg::TIMER1_FLAGS:              return e.timer1;
			iod_pkg::TIMER2_FLAGS:              return e.timer2;
			iod_pkg::PIN_CHANGE_FLAGS:          return e.pin_change;
			iod_pkg::EXTERNAL_IRQ_FLAGS:        return e.ext_irq;
			iod_pkg::SERIAL_PERIPH_STATUS:      return e.spi;
			iod_pkg::COMPARATOR_CONTROL_STATUS: return e.comparator;
			default:                            return 8'h00;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////
	// next-state logic

	// decode, access and flag update in one pass
	always_comb begin
		logic       hit;       // request lands in the 64 locations
		logic       wr;        // request writes
		logic       rd;        // request returns data
		logic       bit_op;    // set/clear: one-bit write
		logic       skip_op;   // skip test
		logic [5:0] idx;       // target location
		logic [7:0] bsel;      // one-hot selected bit
		logic [7:0] wval;      // value presented to the location
		logic [7:0] cur;       // current content of target
		logic [7:0] v;         // location being rebuilt
		logic [7:0] pm;        // plain write mask in effect
		logic [7:0] cm;        // clear-on-one mask in effect
		hit     = 1'b0;
		wr      = 1'b0;
		rd      = 1'b0;
		bit_op  = 1'b0;
		skip_op = 1'b0;
		idx     = 6'h00;
		bsel    = 8'h01 << req.bit_sel;
		wval    = req.wdata;
		cur     = 8'h00;
		v       = 8'h00;
		pm      = 8'h00;
		cm      = 8'h00;
		n       = q;

		// pads pass two flops before anything reads them
		n.sync1 = pins;
		n.sync2 = q.sync1;

		// answers and strobes are single-cycle pulses
		n.rsp      = '0;
		n.ext      = '0;
		n.ext_pend = 1'b0;

		// address decode
		if (req.valid) begin
			unique case (req.op)
				// six address bits reach all 64 locations
				iod_pkg::OP_IO_IN: begin
					idx = req.addr[5:0];
					hit = 1'b1;
					rd  = 1'b1;
				end
				iod_pkg::OP_IO_OUT: begin
					idx = req.addr[5:0];
					hit = 1'b1;
					wr  = 1'b1;
				end
				// bit ops stop at the low 32
				iod_pkg::OP_SET_IO_BIT, iod_pkg::OP_CLEAR_IO_BIT: begin
					idx = req.addr[5:0];
					if (req.addr[5:0] <= iod_pkg::BIT_OP_LAST) begin
						hit    = 1'b1;
						wr     = 1'b1;
						bit_op = 1'b1;
					end else begin
						n.rsp.err = 1'b1;
					end
				end
				iod_pkg::OP_SKIP_IF_IO_BIT_SET, iod_pkg::OP_SKIP_IF_IO_BIT_CLEAR: begin
					idx = req.addr[5:0];
					if (req.addr[5:0] <= iod_pkg::BIT_OP_LAST) begin
						hit     = 1'b1;
						skip_op = 1'b1;
					end else begin
						n.rsp.err = 1'b1;
					end
				end
				// data space: I/O window shifted by 0x20, then extended area
				iod_pkg::OP_MEMORY_READ, iod_pkg::OP_MEMORY_WRITE: begin
					if (req.addr >= iod_pkg::DATA_IO_BASE
							&& req.addr <= iod_pkg::DATA_IO_LAST) begin
						idx = 6'(req.addr - iod_pkg::DATA_IO_BASE);
						hit = 1'b1;
						wr  = (req.op == iod_pkg::OP_MEMORY_WRITE);
						rd  = (req.op == iod_pkg::OP_MEMORY_READ);
					end else if (req.addr >= iod_pkg::DATA_EXT_BASE) begin
						n.ext.strobe = 1'b1;
						n.ext.we     = (req.op == iod_pkg::OP_MEMORY_WRITE);
						n.ext.addr   = req.addr;
						n.ext.wdata  = req.wdata;
						n.ext_pend   = (req.op == iod_pkg::OP_MEMORY_READ);
					end else begin
						// working registers are not ours: read zero
						n.rsp.rvalid = (req.op == iod_pkg::OP_MEMORY_READ);
					end
				end
				default: begin
					// idle cycle
				end
			endcase
		end

		// read path: stored bits only ever hold defined fields
		cur = q.mem[idx];
		if (hit && rd) begin
			n.rsp.rvalid = 1'b1;
			n.rsp.rdata  = cur;
		end
		if (skip_op) begin
			n.rsp.skip_valid = 1'b1;
			n.rsp.skip       = (req.op == iod_pkg::OP_SKIP_IF_IO_BIT_SET)
				? cur[req.bit_sel] : ~cur[req.bit_sel];
		end

		// extended read data arrives in the strobe cycle
		if (q.ext_pend) begin
			n.rsp.rvalid = 1'b1;
			n.rsp.rdata  = ext_rdata;
		end

		// bit ops present all-ones or all-zeros, masked to one bit
		if (bit_op) begin
			wval = (req.op == iod_pkg::OP_SET_IO_BIT) ? 8'hFF : 8'h00;
		end

		// rebuild every location
		for (int i = 0; i < iod_pkg::IO_LOCATIONS; i++) begin
			v  = q.mem[i];
			pm = iod_pkg::wr_mask(6'(i));
			cm = iod_pkg::w1c_mask(6'(i));
			if (bit_op) begin
				pm = pm & bsel;
				cm = cm & bsel;
			end
			if (hit && wr && idx == 6'(i)) begin
				// reserved bits and locations have no mask: write ignored
				v = (v & ~pm) | (wval & pm);
				v = v & ~(wval & cm);
			end
			// a flag raised in the clearing cycle survives
			v = v | (evt_value(6'(i), evt) & iod_pkg::w1c_mask(6'(i)));
			// pad and comparator levels overwrite their bits every cycle
			v = (v & ~iod_pkg::lvl_mask(6'(i)))
				| (lvl_value(6'(i), q.sync2) & iod_pkg::lvl_mask(6'(i)));
			n.mem[i] = v;
		end

		// reset values
		if (rst) begin
			for (int i = 0; i < iod_pkg::IO_LOCATIONS; i++) begin
				n.mem[i] = iod_pkg::REG_RESET;
			end
			n.sync1    = '0;
			n.sync2    = '0;
			n.rsp      = '0;
			n.ext      = '0;
			n.ext_pend = 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// state register

	// everything is held here; reset is folded into n
	always_ff @(posedge mclk) begin
		q <= n;
	end

	////////////////////////////////////////////////////////////////////////
	// outputs, straight from flops

	assign rsp         = q.rsp;
	assign ext         = q.ext;
	assign ports.b_dir = q.mem[iod_pkg::PORT_B_DIRECTION];
	assign ports.b_out = q.mem[iod_pkg::PORT_B_OUTPUT];
	assign ports.c_dir = q.mem[iod_pkg::PORT_C_DIRECTION];
	assign ports.c_out = q.mem[iod_pkg::PORT_C_OUTPUT];
	assign ports.d_dir = q.mem[iod_pkg::PORT_D_DIRECTION];
	assign ports.d_out = q.mem[iod_pkg::PORT_D_OUTPUT];
	assign ports.e_dir = q.mem[iod_pkg::PORT_E_DIRECTION];
	assign ports.e_out = q.mem[iod_pkg::PORT_E_OUTPUT];

endmodule

// >>> src/iod_pkg.sv
// iod_pkg: register map, field masks, carriers and ops of the I/O register space
package iod_pkg;

	// I/O-space offsets, as used by the dedicated transfer ops
	localparam logic [5:0] PORT_B_PIN_INPUT          = 6'h03;
	localparam logic [5:0] PORT_B_DIRECTION          = 6'h04;
	localparam logic [5:0] PORT_B_OUTPUT             = 6'h05;
	localparam logic [5:0] PORT_C_PIN_INPUT          = 6'h06;
	localparam logic [5:0] PORT_C_DIRECTION          = 6'h07;
	localparam logic [5:0] PORT_C_OUTPUT             = 6'h08;
	localparam logic [5:0] PORT_D_PIN_INPUT          = 6'h09;
	localparam logic [5:0] PORT_D_DIRECTION          = 6'h0A;
	localparam logic [5:0] PORT_D_OUTPUT             = 6'h0B;
	localparam logic [5:0] PORT_E_PIN_INPUT          = 6'h0C;
	localparam logic [5:0] PORT_E_DIRECTION          = 6'h0D;
	localparam logic [5:0] PORT_E_OUTPUT             = 6'h0E;
	localparam logic [5:0] TIMER0_FLAGS              = 6'h15;
	localparam logic [5:0] TIMER1_FLAGS              = 6'h16;
	localparam logic [5:0] TIMER2_FLAGS              = 6'h17;
	localparam logic [5:0] PIN_CHANGE_FLAGS          = 6'h1B;
	localparam logic [5:0] EXTERNAL_IRQ_FLAGS        = 6'h1C;
	localparam logic [5:0] EXTERNAL_IRQ_MASK         = 6'h1D;
	localparam logic [5:0] GENERAL_SCRATCH_0         = 6'h1E;
	localparam logic [5:0] NVM_CONTROL               = 6'h1F;
	localparam logic [5:0] NVM_DATA                  = 6'h20;
	localparam logic [5:0] NVM_ADDRESS_LOW           = 6'h21;
	localparam logic [5:0] NVM_ADDRESS_HIGH          = 6'h22;
	localparam logic [5:0] PRESCALER_SYNC_CONTROL    = 6'h23;
	localparam logic [5:0] TIMER0_CONTROL_A          = 6'h24;
	localparam logic [5:0] TIMER0_CONTROL_B          = 6'h25;
	localparam logic [5:0] TIMER0_COUNT              = 6'h26;
	localparam logic [5:0] TIMER0_COMPARE_A          = 6'h27;
	localparam logic [5:0] TIMER0_COMPARE_B          = 6'h28;
	localparam logic [5:0] GENERAL_SCRATCH_1         = 6'h2A;
	localparam logic [5:0] GENERAL_SCRATCH_2         = 6'h2B;
	localparam logic [5:0] SERIAL_PERIPH_CONTROL     = 6'h2C;
	localparam logic [5:0] SERIAL_PERIPH_STATUS      = 6'h2D;
	localparam logic [5:0] SERIAL_PERIPH_DATA        = 6'h2E;
	localparam logic [5:0] COMPARATOR_OUTPUT_ENABLE  = 6'h2F;
	localparam logic [5:0] COMPARATOR_CONTROL_STATUS = 6'h30;

	// address windows
	localparam logic [5:0] BIT_OP_LAST   = 6'h1F;  // last bit-addressable location
	localparam logic [7:0] DATA_IO_BASE  = 8'h20;  // data address of I/O location 0
	localparam logic [7:0] DATA_IO_LAST  = 8'h5F;  // data address of I/O location 63
	localparam logic [7:0] DATA_EXT_BASE = 8'h60;  // first extended location
	localparam int         IO_LOCATIONS  = 64;     // locations the transfer ops encode

	// values after reset
	localparam logic [7:0] REG_RESET     = 8'h00;

	// core operations on the register space
	typedef enum logic [3:0] {
		OP_NONE,
		OP_IO_IN,
		OP_IO_OUT,
		OP_SET_IO_BIT,
		OP_CLEAR_IO_BIT,
		OP_SKIP_IF_IO_BIT_SET,
		OP_SKIP_IF_IO_BIT_CLEAR,
		OP_MEMORY_READ,
		OP_MEMORY_WRITE
	} iod_op_e;

	// one request from the execution unit
	typedef struct packed {
		logic       valid;  // request this cycle
		iod_op_e    op;     // operation
		logic [7:0] addr;   // I/O address (low 6 bits) or data address
		logic [2:0] bit_sel;  // bit for set/clear/skip
		logic [7:0] wdata;  // write data
	} iod_req_s;

	// answer to the execution unit
	typedef struct packed {
		logic       rvalid;  // read data valid
		logic [7:0] rdata;   // read data
		logic       skip_valid;  // skip decision valid
		logic       skip;    // skip next instruction
		logic       err;     // refused request
	} iod_rsp_s;

	// access forwarded to the extended register area
	typedef struct packed {
		logic       strobe;  // access this cycle
		logic       we;      // write
		logic [7:0] addr;    // data address 0x60..0xFF
		logic [7:0] wdata;   // write data
	} iod_ext_s;

	// levels from the pads and the comparator (asynchronous)
	typedef struct packed {
		logic [7:0] b;
		logic [7:0] c;
		logic [7:0] d;
		logic [7:0] e;
		logic       ac_out;
	} iod_pins_s;

	// one-cycle flag set events from the peripherals
	typedef struct packed {
		logic [7:0] timer0;
		logic [7:0] timer1;
		logic [7:0] timer2;
		logic [7:0] pin_change;
		logic [7:0] ext_irq;
		logic [7:0] spi;
		logic [7:0] comparator;
	} iod_evt_s;

	// port configuration seen by the pad logic
	typedef struct packed {
		logic [7:0] b_dir;
		logic [7:0] b_out;
		logic [7:0] c_dir;
		logic [7:0] c_out;
		logic [7:0] d_dir;
		logic [7:0] d_out;
		logic [7:0] e_dir;
		logic [7:0] e_out;
	} iod_ports_s;

	// software-writable plain bits of each location
	function automatic logic [7:0] wr_mask(input logic [5:0] a);
		unique case (a)
			PORT_B_DIRECTION, PORT_B_OUTPUT,
			PORT_D_DIRECTION, PORT_D_OUTPUT,
			GENERAL_SCRATCH_0, NVM_DATA, NVM_ADDRESS_LOW, NVM_ADDRESS_HIGH,
			TIMER0_COUNT, TIMER0_COMPARE_A, TIMER0_COMPARE_B,
			GENERAL_SCRATCH_1, GENERAL_SCRATCH_2,
			SERIAL_PERIPH_CONTROL, SERIAL_PERIPH_DATA:  return 8'hFF;
			PORT_C_DIRECTION, PORT_C_OUTPUT:            return 8'h7F;
			PORT_E_DIRECTION, PORT_E_OUTPUT:            return 8'h0F;
			EXTERNAL_IRQ_MASK:                          return 8'h03;
			NVM_CONTROL:                                return 8'h3F;
			PRESCALER_SYNC_CONTROL:                     return 8'h83;
			TIMER0_CONTROL_A:                           return 8'hF3;
			TIMER0_CONTROL_B:                           return 8'h0F;
			SERIAL_PERIPH_STATUS:                       return 8'h01;
			COMPARATOR_OUTPUT_ENABLE:                   return 8'h01;
			COMPARATOR_CONTROL_STATUS:                  return 8'hCF;
			default:                                    return 8'h00;
		endcase
	endfunction

	// status flags cleared by writing a one
	function automatic logic [7:0] w1c_mask(input logic [5:0] a);
		unique case (a)
			TIMER0_FLAGS, TIMER2_FLAGS, PIN_CHANGE_FLAGS: return 8'h07;
			TIMER1_FLAGS:                                 return 8'h27;
			EXTERNAL_IRQ_FLAGS:                           return 8'h03;
			SERIAL_PERIPH_STATUS:                         return 8'hC0;
			COMPARATOR_CONTROL_STATUS:                    return 8'h10;
			default:                                      return 8'h00;
		endcase
	endfunction

	// bits that follow a live hardware level
	function automatic logic [7:0] lvl_mask(input logic [5:0] a);
		unique case (a)
			PORT_B_PIN_INPUT, PORT_D_PIN_INPUT: return 8'hFF;
			PORT_C_PIN_INPUT:                   return 8'h7F;
			PORT_E_PIN_INPUT:                   return 8'h0F;
			COMPARATOR_CONTROL_STATUS:          return 8'h20;
			default:                            return 8'h00;
		endcase
	endfunction

endpackage

// >>> tb/iod_io_space_monitor.sv
// iod_io_space_monitor: port-level assertions for the I/O register space
`timescale 1ns/1ps
////////////////////////////////////////////////////////////
module iod_io_space_chk (
	input wire logic              mclk,      // system clock
	input wire logic              rst,       // sync reset, high
	input wire iod_pkg::iod_req_s req,       // request from core
	input wire iod_pkg::iod_rsp_s rsp,       // answer to core
	input wire iod_pkg::iod_ext_s ext,       // extended area access
	input wire logic [7:0]        ext_rdata  // extended read data
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	// decoded request kinds, plain nets so properties stay short
	wire logic skip_op = req.valid && (req.op inside {iod_pkg::OP_SKIP_IF_IO_BIT_SET,
		iod_pkg::OP_SKIP_IF_IO_BIT_CLEAR});
	wire logic bit_op  = skip_op || (req.valid && (req.op inside {iod_pkg::OP_SET_IO_BIT,
		iod_pkg::OP_CLEAR_IO_BIT}));
	wire logic low_adr = req.addr[5:0] <= iod_pkg::BIT_OP_LAST;  // bit-addressable
	wire logic io_in   = req.valid && req.op == iod_pkg::OP_IO_IN;
	wire logic mrd     = req.valid && req.op == iod_pkg::OP_MEMORY_READ;
	wire logic mwr     = req.valid && req.op == iod_pkg::OP_MEMORY_WRITE;
	wire logic ext_adr = req.addr >= iod_pkg::DATA_EXT_BASE;  // beyond the 64 locations

	// extended read: strobe one edge on, data back the edge after
	sequence ext_rd_req;
		mrd && ext_adr;
	endsequence
	sequence ext_rd_ans;
		##1 (ext.strobe && !ext.we && ext.addr == $past(req.addr))
		##1 (rsp.rvalid && rsp.rdata == $past(ext_rdata));
	endsequence

	chk_bit_refused: assert property (bit_op && !low_adr |=> rsp.err && !rsp.skip_valid)
		else $error("bit op above 0x1F not refused");
	chk_bit_taken: assert property (bit_op && low_adr |=> !rsp.err)
		else $error("bit op in low range refused");
	chk_skip_answer: assert property (skip_op && low_adr |=> rsp.skip_valid)
		else $error("skip op gave no decision");
	chk_io_read: assert property (io_in |=> rsp.rvalid && !ext.strobe)
		else $error("transfer read not answered from I/O space");
	chk_data_window: assert property (mrd && req.addr >= iod_pkg::DATA_IO_BASE &&
		req.addr <= iod_pkg::DATA_IO_LAST |=> rsp.rvalid && !ext.strobe)
		else $error("data window read not answered internally");
	chk_ext_read: assert property (ext_rd_req |-> ext_rd_ans)
		else $error("extended read sequence wrong");
	chk_ext_write: assert property (mwr && ext_adr |=> ext.strobe && ext.we &&
		ext.wdata == $past(req.wdata))
		else $error("extended write not forwarded");
	chk_ext_cause: assert property (ext.strobe |-> $past(req.valid) &&
		$past(req.op) inside {iod_pkg::OP_MEMORY_READ, iod_pkg::OP_MEMORY_WRITE} &&
		$past(req.addr) >= iod_pkg::DATA_EXT_BASE)
		else $error("extended access without memory op");
	chk_reserved_zero: assert property (io_in && req.addr[5:0] inside {6'h00, 6'h01,
		6'h02, [6'h0F:6'h14], 6'h18, 6'h19, 6'h29, 6'h31, 6'h32} |=> rsp.rdata == 8'h00)
		else $error("reserved location read nonzero");
endmodule

bind iod_io_space iod_io_space_chk u_chk (.mclk(mclk), .rst(rst), .req(req), .rsp(rsp),
	.ext(ext), .ext_rdata(ext_rdata));

// >>> tb/iod_exu_model.sv
// iod_exu_model: execution unit issuing register-space requests
`timescale 1ns/1ps
////////////////////////////////////////////////////////////
module iod_exu_model (
	input  wire logic              mclk,  // system clock
	output iod_pkg::iod_req_s      req,   // request to register space
	input  wire iod_pkg::iod_rsp_s rsp,   // answer
	input  wire iod_pkg::iod_ext_s ext    // extended access seen
);
	iod_pkg::iod_rsp_s a1;  // answer one edge after the take
	iod_pkg::iod_rsp_s a2;  // answer two edges after, extended reads
	iod_pkg::iod_ext_s x1;  // extended access one edge after

	initial req = '0;

	// one request held for the single edge that takes it; the idle
	// cycles after it keep a later read clear of an extended answer
	// callers only write zero to reserved bits and never reserved places
	task automatic xfer(input iod_pkg::iod_op_e o, input logic [7:0] a,
		input logic [2:0] b, input logic [7:0] d);
		@(posedge mclk);
		#1 req = '{valid: 1'b1, op: o, addr: a, bit_sel: b, wdata: d};
		@(posedge mclk);
		// the answer launched by the taking edge stands for one cycle only
		#1 req = '0;
		a1 = rsp;
		x1 = ext;
		@(posedge mclk);
		#1 a2 = rsp;
	endtask
endmodule

// >>> tb/tb.sv
// tb: self-checking bench for the I/O register space
`timescale 1ns/1ps
////////////////////////////////////////////////////////////
module tb;
	logic                mclk = 1'b0;   // 20 MHz clock
	logic                rst  = 1'b1;   // sync reset
	iod_pkg::iod_req_s   req;           // from execution unit
	iod_pkg::iod_rsp_s   rsp;           // to execution unit
	iod_pkg::iod_pins_s  pins;          // pad levels
	iod_pkg::iod_evt_s   evt;           // flag events
	iod_pkg::iod_ports_s ports;         // port config
	iod_pkg::iod_ext_s   ext;           // extended access
	logic [7:0]          ext_rdata;     // extended read data
	logic [7:0]          noise = 8'h00; // busy pattern outside strobes
	int                  num_errors  = 0;
	int                  comparisons = 0;
	localparam logic [5:0] RW_A [6] = '{6'h05, 6'h08, 6'h0E, 6'h1D, 6'h1E, 6'h2C};
	localparam logic [7:0] RW_M [6] = '{8'hFF, 8'h7F, 8'h0F, 8'h03, 8'hFF, 8'hFF};

	always #25 mclk = ~mclk;
	always @(posedge mclk) noise <= noise + 8'h3B;
	// extended area: data only in the strobe cycle, otherwise churn
	assign ext_rdata = (ext.strobe && !ext.we) ? (ext.addr ^ 8'h5A) : noise;

	iod_io_space uut (.mclk(mclk), .rst(rst), .req(req), .rsp(rsp), .pins(pins), .evt(evt),
		.ports(ports), .ext(ext), .ext_rdata(ext_rdata));
	iod_exu_model exu (.mclk(mclk), .req(req), .rsp(rsp), .ext(ext));

	////////////////////////////////////////////////////////////
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);  // transfer read
		exu.xfer(iod_pkg::OP_IO_IN, a, 3'h0, 8'h00);
		chk({7'h00, exu.a1.rvalid, exu.a1.rdata}, {8'h01, e});
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);  // transfer write
		exu.xfer(iod_pkg::OP_IO_OUT, a, 3'h0, d);
	endtask
	task automatic bop(input iod_pkg::iod_op_e o, input logic [7:0] a, input logic [2:0] b,
		input logic [2:0] e);  // bit op, expect skip_valid, skip, err
		exu.xfer(o, a, b, 8'h00);
		chk({13'h0000, exu.a1.skip_valid, exu.a1.skip, exu.a1.err}, {13'h0000, e});
	endtask
	task automatic conclude();
		$display("comparisons %0d num_errors %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	////////////////////////////////////////////////////////////
	// both address routes reach the same plain registers
	task automatic t_map();
		chk(16'(|ports), 16'h0000);  // ports clear after reset
		for (int i = 0; i < 6; i++) begin
			rd({2'b00, RW_A[i]}, 8'h00);  // reset value
			wr({2'b00, RW_A[i]}, RW_M[i]);
			rd({2'b00, RW_A[i]}, RW_M[i]);
			exu.xfer(iod_pkg::OP_MEMORY_READ, {2'b00, RW_A[i]} + 8'h20, 3'h0, 8'h00);
			chk({7'h00, exu.a1.rvalid, exu.a1.rdata}, {8'h01, RW_M[i]});
			exu.xfer(iod_pkg::OP_MEMORY_WRITE, {2'b00, RW_A[i]} + 8'h20, 3'h0, 8'h00);
			rd({2'b00, RW_A[i]}, 8'h00);
		end
		wr(8'h05, 8'hA5);
		chk({8'h00, ports.b_out}, 16'h00A5);
	endtask
	// reserved places read as zero, low data addresses too
	task automatic t_reserved();
		rd(8'h00, 8'h00);
		rd(8'h29, 8'h00);
		rd(8'h31, 8'h00);
		exu.xfer(iod_pkg::OP_MEMORY_READ, 8'h10, 3'h0, 8'h00);
		chk({6'h00, exu.a1.rvalid, exu.a1.err, exu.a1.rdata}, 16'h0200);
	endtask
	// set, clear and skip stay inside the low 32 and touch one bit
	task automatic t_bits();
		wr(8'h05, 8'h81);
		bop(iod_pkg::OP_SET_IO_BIT, 8'h05, 3'h3, 3'b000);
		rd(8'h05, 8'h89);
		bop(iod_pkg::OP_CLEAR_IO_BIT, 8'h05, 3'h0, 3'b000);
		rd(8'h05, 8'h88);
		bop(iod_pkg::OP_SKIP_IF_IO_BIT_SET, 8'h05, 3'h3, 3'b110);
		bop(iod_pkg::OP_SKIP_IF_IO_BIT_SET, 8'h05, 3'h2, 3'b100);
		bop(iod_pkg::OP_SKIP_IF_IO_BIT_CLEAR, 8'h05, 3'h2, 3'b110);
		bop(iod_pkg::OP_SKIP_IF_IO_BIT_CLEAR, 8'h05, 3'h7, 3'b100);
		bop(iod_pkg::OP_SET_IO_BIT, 8'h2C, 3'h0, 3'b001);
		bop(iod_pkg::OP_CLEAR_IO_BIT, 8'h20, 3'h0, 3'b001);
		bop(iod_pkg::OP_SKIP_IF_IO_BIT_SET, 8'h3F, 3'h0, 3'b001);
		rd(8'h2C, 8'h00);
	endtask
	// flags set by events, cleared by writing one
	task automatic t_w1c();
		@(posedge mclk);
		#1 evt.timer0 = 8'h07;
		evt.ext_irq = 8'h03;
		@(posedge mclk);
		#1 evt = '0;
		rd(8'h15, 8'h07);
		wr(8'h15, 8'h02);
		rd(8'h15, 8'h05);
		bop(iod_pkg::OP_SET_IO_BIT, 8'h15, 3'h0, 3'b000);
		rd(8'h15, 8'h04);
		bop(iod_pkg::OP_CLEAR_IO_BIT, 8'h15, 3'h2, 3'b000);
		rd(8'h15, 8'h04);
		wr(8'h1C, 8'h01);
		rd(8'h1C, 8'h02);
	endtask
	// pad levels through the synchroniser, reserved pin bit hidden
	task automatic t_pins();
		@(posedge mclk);
		#1 pins = '{b: 8'h3C, c: 8'hFF, d: 8'h00, e: 8'h00, ac_out: 1'b1};
		repeat (3) @(posedge mclk);
		rd(8'h03, 8'h3C);
		rd(8'h06, 8'h7F);
		rd(8'h30, 8'h20);
	endtask
	// extended area only by memory ops; transfer ops see 64 places
	task automatic t_ext();
		exu.xfer(iod_pkg::OP_MEMORY_WRITE, 8'h80, 3'h0, 8'h3C);
		chk({6'h00, exu.x1.strobe, exu.x1.we, exu.x1.addr}, 16'h0380);
		chk({8'h00, exu.x1.wdata}, 16'h003C);
		exu.xfer(iod_pkg::OP_MEMORY_READ, 8'hFF, 3'h0, 8'h00);
		chk({7'h00, exu.a2.rvalid, exu.a2.rdata}, 16'h01A5);
		wr(8'hE0, 8'h66);
		chk({15'h0000, exu.x1.strobe}, 16'h0000);
		exu.xfer(iod_pkg::OP_IO_IN, 8'hA0, 3'h0, 8'h00);
		chk({6'h00, exu.x1.strobe, exu.a1.rvalid, exu.a1.rdata}, 16'h0166);
	endtask

	////////////////////////////////////////////////////////////
	initial begin
		pins = '0;
		evt  = '0;
		repeat (16) @(posedge mclk);
		#1 rst = 1'b0;
		t_map();
		t_reserved();
		t_bits();
		t_w1c();
		t_pins();
		t_ext();
		conclude();
	end
	// watchdog: the run needs well under 1000 cycles
	initial begin
		#50000;
		num_errors++;
		conclude();
	end
endmodule
